/* File: verilog/sfr_read_top.sv */
// sfr_read_top: serial command decoder and main memory read datapath.
// assumes: serial pins and reset pin are asynchronous to ref_clk_i and are
// oversampled; the serial clock runs well below a quarter of ref_clk_i.
`timescale 1ns/1ps
module sfr_read_top
    import sfr_pkg::*;
#(
    parameter int PAGES = SFR_PAGES
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    sck_i,
    input  wire logic                    si_i,
    input  wire logic                    flash_reset_n_i,
    input  wire logic                    binary_page_i,
    output logic                         so_o,
    output logic                         so_oe_o,
    input  wire logic                    fill_en_i,
    input  wire logic [SFR_ARRAY_AW-1:0] fill_addr_i,
    input  wire logic [7:0]              fill_data_i
);

    typedef struct packed {
        sfr_state_t              st;
        logic                    sck_q;      // previous synced serial clock
        logic                    cs_n_q;     // previous synced chip select
        logic [5:0]              bit_cnt;    // bits taken in this phase
        logic [7:0]              opcode;
        logic [23:0]             addr_sh;
        logic [5:0]              fill_bits;  // filler length of this command
        logic                    page_only;  // wrap inside the page
        logic                    binary;     // 256-byte page form
        logic [SFR_PAGE_W-1:0]   page;       // page_number_field
        logic [SFR_BYTE_W-1:0]   byte_ofs;   // page_byte_offset
        logic [SFR_ARRAY_AW-1:0] mem_addr;
        logic                    rd_req;
        logic                    pend_load;
        logic [7:0]              pend;       // next byte to send
        logic [7:0]              shout;      // bits still to send
        logic [3:0]              out_left;
        logic                    so;
        logic                    so_oe;
    } sfr_top_state_t;

    sfr_top_state_t r_reg;
    sfr_top_state_t r_next;

    logic [3:0] pins_sync;
    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic       frst_n_s;
    logic       binary_s;
    logic [7:0] mem_data;

    initial begin
        if (PAGES != (1 << SFR_PAGE_W)) begin
            $error("sfr_read_top: PAGES must match the page number width");
        end
    end

    // pins cross into the ref_clk_i domain
    sfr_sync #(
        .WIDTH   (4),
        .RST_VAL (4'h9)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({cs_n_i, sck_i, si_i, flash_reset_n_i}),
        .sync_o    (pins_sync)
    );

    sfr_sync #(
        .WIDTH   (1),
        .RST_VAL (1'b0)
    ) u_mode_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (binary_page_i),
        .sync_o    (binary_s)
    );

    assign cs_n_s   = pins_sync[3];
    assign sck_s    = pins_sync[2];
    assign si_s     = pins_sync[1];
    assign frst_n_s = pins_sync[0];

    // main array, read only from this block
    sfr_array #(
        .DEPTH (SFR_DEPTH),
        .AW    (SFR_ARRAY_AW),
        .DW    (8)
    ) u_array (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .rd_en_i   (r_reg.rd_req),
        .rd_addr_i (r_reg.mem_addr),
        .rd_data_o (mem_data),
        .wr_en_i   (fill_en_i),
        .wr_addr_i (fill_addr_i),
        .wr_data_i (fill_data_i)
    );

    // linear array index at a fixed stride of 264 bytes per page
    function automatic logic [SFR_ARRAY_AW-1:0] sfr_lin(input logic [SFR_PAGE_W-1:0] pg,
                                                        input logic [SFR_BYTE_W-1:0] ofs);
        logic [SFR_ARRAY_AW-1:0] base;
        base    = {pg, 9'h000} - {1'b0, pg, 8'h00} + {6'h00, pg, 3'h0};
        sfr_lin = base + {10'h000, ofs};
    endfunction : sfr_lin

    // command sequencing and read datapath
    always_comb begin
        logic                  sck_rise;
        logic                  sck_fall;
        logic [5:0]            cnt_inc;
        logic [23:0]           addr_full;
        logic [SFR_BYTE_W-1:0] last_ofs;
        logic [5:0]            fill_len;
        sck_rise  = 1'b0;
        sck_fall  = 1'b0;
        cnt_inc   = 6'h00;
        addr_full = 24'h000000;
        last_ofs  = SFR_LAST_WIDE;
        fill_len  = 6'h00;

        r_next           = r_reg;
        r_next.sck_q     = sck_s;
        r_next.cs_n_q    = cs_n_s;
        r_next.rd_req    = 1'b0;
        r_next.pend_load = r_reg.rd_req;
        sck_rise         = sck_s & ~r_reg.sck_q;
        sck_fall         = ~sck_s & r_reg.sck_q;
        cnt_inc          = r_reg.bit_cnt + 6'h01;
        last_ofs         = r_reg.binary ? SFR_LAST_NARROW : SFR_LAST_WIDE;

        // fetched byte lands in the pending slot
        if (r_reg.pend_load) begin
            r_next.pend = mem_data;
        end

        unique case (r_reg.st)
            SFR_IDLE: begin
                if (r_reg.cs_n_q && !cs_n_s) begin
                    r_next.st      = SFR_OPCODE;
                    r_next.bit_cnt = 6'h00;
                end
            end
            SFR_OPCODE: begin
                if (sck_rise) begin
                    r_next.opcode  = {r_reg.opcode[6:0], si_s};
                    r_next.bit_cnt = cnt_inc;
                    if (cnt_inc == SFR_OPCODE_BITS) begin
                        r_next.bit_cnt = 6'h00;
                        r_next.binary  = binary_s;
                        unique case ({r_reg.opcode[6:0], si_s})
                            SFR_OP_LEGACY_READ: begin
                                r_next.st        = SFR_ADDR;
                                r_next.fill_bits = SFR_FILL4_BITS;
                                r_next.page_only = 1'b0;
                            end
                            SFR_OP_FAST_READ: begin
                                r_next.st        = SFR_ADDR;
                                r_next.fill_bits = SFR_FILL1_BITS;
                                r_next.page_only = 1'b0;
                            end
                            SFR_OP_SLOW_READ: begin
                                r_next.st        = SFR_ADDR;
                                r_next.fill_bits = 6'h00;
                                r_next.page_only = 1'b0;
                            end
                            SFR_OP_PAGE_READ: begin
                                r_next.st        = SFR_ADDR;
                                r_next.fill_bits = SFR_FILL4_BITS;
                                r_next.page_only = 1'b1;
                            end
                            default: begin
                                r_next.st = SFR_IGNORE;
                            end
                        endcase
                    end
                end
            end
            SFR_ADDR: begin
                if (sck_rise) begin
                    addr_full      = {r_reg.addr_sh[22:0], si_s};
                    r_next.addr_sh = addr_full;
                    r_next.bit_cnt = cnt_inc;
                    if (cnt_inc == SFR_ADDR_BITS) begin
                        r_next.bit_cnt = 6'h00;
                        // unused high bits are dropped
                        if (r_reg.binary) begin
                            r_next.page     = addr_full[17:8];
                            r_next.byte_ofs = {1'b0, addr_full[7:0]};
                        end else begin
                            r_next.page     = addr_full[18:9];
                            r_next.byte_ofs = addr_full[8:0];
                        end
                        fill_len = r_reg.fill_bits;
                        if (fill_len == 6'h00) begin
                            r_next.st = SFR_DATA;
                        end else begin
                            r_next.st = SFR_FILL;
                        end
                        // first fetch starts at once; the filler, or for the slow read the high half of the last address bit, hides it
                        r_next.mem_addr = r_reg.binary ?
                                          sfr_lin(addr_full[17:8], {1'b0, addr_full[7:0]}) :
                                          sfr_lin(addr_full[18:9], addr_full[8:0]);
                        r_next.rd_req   = 1'b1;
                        r_next.out_left = 4'h0;
                    end
                end
            end
            SFR_FILL: begin
                if (sck_rise) begin
                    r_next.bit_cnt = cnt_inc;
                    if (cnt_inc == r_reg.fill_bits) begin
                        r_next.bit_cnt = 6'h00;
                        r_next.st      = SFR_DATA;
                    end
                end
            end
            SFR_DATA: begin
                if (sck_fall) begin
                    r_next.so_oe = 1'b1;
                    if (r_reg.out_left == 4'h0) begin
                        // start a new byte and fetch the one after it
                        r_next.so       = r_reg.pend[7];
                        r_next.shout    = {r_reg.pend[6:0], 1'b0};
                        r_next.out_left = SFR_BYTE_BITS - 4'h1;
                        if (r_reg.byte_ofs >= last_ofs) begin
                            r_next.byte_ofs = '0;
                            if (!r_reg.page_only) begin
                                r_next.page = r_reg.page + 10'h001;
                            end
                        end else begin
                            r_next.byte_ofs = r_reg.byte_ofs + 9'h001;
                        end
                        r_next.mem_addr = sfr_lin(r_next.page, r_next.byte_ofs);
                        r_next.rd_req   = 1'b1;
                    end else begin
                        r_next.so       = r_reg.shout[7];
                        r_next.shout    = {r_reg.shout[6:0], 1'b0};
                        r_next.out_left = r_reg.out_left - 4'h1;
                    end
                end
            end
            SFR_IGNORE: begin
                r_next.so_oe = 1'b0;
            end
        endcase

        // deselect ends any command and floats the output
        if (cs_n_s) begin
            r_next.st       = SFR_IDLE;
            r_next.so_oe    = 1'b0;
            r_next.so       = 1'b0;
            r_next.out_left = 4'h0;
            r_next.bit_cnt  = 6'h00;
        end

        // reset pin holds the sequencer idle
        if (!frst_n_s) begin
            r_next.st       = SFR_IDLE;
            r_next.so_oe    = 1'b0;
            r_next.so       = 1'b0;
            r_next.out_left = 4'h0;
            r_next.bit_cnt  = 6'h00;
            r_next.rd_req   = 1'b0;
        end
    end

    // mode 0 and mode 3 both reduce to the same edge pattern
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg        <= '0;
            r_reg.st     <= SFR_IDLE;
            r_reg.cs_n_q <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign so_o    = r_reg.so;
    assign so_oe_o = r_reg.so_oe;

endmodule : sfr_read_top

/* File: verilog/sfr_pkg.sv */
// sfr_pkg: constants and types shared by the serial flash read front end.
// assumes: byte-wide main array, 1024 pages, stored at a fixed stride of 264 bytes.
package sfr_pkg;

    // opcodes of the supported main memory reads
    localparam logic [7:0] SFR_OP_LEGACY_READ = 8'he8;
    localparam logic [7:0] SFR_OP_FAST_READ   = 8'h0b;
    localparam logic [7:0] SFR_OP_SLOW_READ   = 8'h03;
    localparam logic [7:0] SFR_OP_PAGE_READ   = 8'hd2;

    // array geometry
    localparam int          SFR_PAGES         = 1024;
    localparam int          SFR_PAGE_W        = 10;   // page_number_field width
    localparam int          SFR_BYTE_W        = 9;    // page_byte_offset width
    localparam int          SFR_NARROW_BYTE_W = 8;    // binary_linear_address byte part
    localparam int          SFR_ARRAY_AW      = 19;
    localparam int          SFR_STRIDE        = 264;  // physical bytes per page
    localparam int          SFR_DEPTH         = SFR_PAGES * SFR_STRIDE;
    localparam logic [8:0]  SFR_LAST_WIDE     = 9'h107;  // last offset, 264-byte pages
    localparam logic [8:0]  SFR_LAST_NARROW   = 9'h0ff;  // last offset, 256-byte pages

    // buffer offset widths, kept for completeness of the addressing forms
    localparam int          SFR_BUF_OFS_WIDE_W   = 9;  // buffer_byte_offset_wide
    localparam int          SFR_BUF_OFS_NARROW_W = 8;  // buffer_byte_offset_narrow

    // serial framing counts, in serial clock bits
    localparam logic [5:0]  SFR_OPCODE_BITS   = 6'h08;
    localparam logic [5:0]  SFR_ADDR_BITS     = 6'h18;
    localparam logic [5:0]  SFR_FILL4_BITS    = 6'h20;  // four filler bytes
    localparam logic [5:0]  SFR_FILL1_BITS    = 6'h08;  // one dummy byte
    localparam logic [3:0]  SFR_BYTE_BITS     = 4'h8;

    // serial clock ceilings of the read commands, in MHz
    localparam int          SFR_HIGH_READ_CLOCK_LIMIT_MHZ = 66;
    localparam int          SFR_LOW_READ_CLOCK_LIMIT_MHZ  = 33;

    // value returned where the address leaves the array
    localparam logic [7:0]  SFR_BLANK_BYTE    = 8'hff;

    typedef enum logic [2:0] {
        SFR_IDLE,
        SFR_OPCODE,
        SFR_ADDR,
        SFR_FILL,
        SFR_DATA,
        SFR_IGNORE
    } sfr_state_t;

endpackage : sfr_pkg

/* File: verilog/sfr_sync.sv */
// sfr_sync: two-flop synchroniser for a group of asynchronous levels.
// assumes: inputs are slow levels from pins; each bit is crossed independently.
`timescale 1ns/1ps
module sfr_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sfr_sync_state_t;

    sfr_sync_state_t r_reg;
    sfr_sync_state_t r_next;

    initial begin
        if (WIDTH < 1) begin
            $error("sfr_sync: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second
    always_comb begin
        r_next        = r_reg;
        r_next.meta   = async_i;
        r_next.stable = r_reg.meta;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= {RST_VAL, RST_VAL};
        end else begin
            r_reg <= r_next;
        end
    end

    assign sync_o = r_reg.stable;

endmodule : sfr_sync

/* File: verilog/sfr_array.sv */
// sfr_array: main memory array with registered read and a fill port.
// assumes: one read or fill per clock; contents are undefined until filled.
`timescale 1ns/1ps
module sfr_array #(
    parameter int DEPTH = 270336,
    parameter int AW    = 19,
    parameter int DW    = 8
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          rd_en_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i
);

    typedef struct packed {
        logic [DW-1:0] rd_data;
    } sfr_array_state_t;

    logic [DW-1:0]    mem [DEPTH];
    sfr_array_state_t r_reg;
    sfr_array_state_t r_next;

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin
            $error("sfr_array: DEPTH does not fit the address width");
        end
    end

    // out-of-range reads return an erased-looking byte
    always_comb begin
        r_next = r_reg;
        if (rd_en_i) begin
            if (int'(rd_addr_i) < DEPTH) begin
                r_next.rd_data = mem[rd_addr_i];
            end else begin
                r_next.rd_data = '1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // array storage, no reset
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i && int'(wr_addr_i) < DEPTH) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = r_reg.rd_data;

endmodule : sfr_array

/* File: verif/sfr_read_props.sv */
// sfr_read_props: timing checks on the serial output of the read front end.
// assumes: bound to sfr_read_top; pins reach its logic through 2-flop syncs.
`timescale 1ns/1ps
module sfr_read_props (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic flash_reset_n_i,
    input  wire logic so_o,
    input  wire logic so_oe_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // pins held long enough for the syncs to pass them on
    sequence s_deselected;
        cs_n_i [*5];
    endsequence
    sequence s_in_reset;
        !flash_reset_n_i [*5];
    endsequence
    sequence s_sck_held_high;
        (sck_i && !cs_n_i && flash_reset_n_i) [*6];
    endsequence
    // a serial clock fall landed a few cycles ago
    sequence s_after_fall;
        !sck_i && ($past(sck_i, 2) || $past(sck_i, 3) || $past(sck_i, 4)
                   || $past(sck_i, 5) || $past(sck_i, 6));
    endsequence

    AST_DESELECT_TRISTATE: assert property (s_deselected |-> !so_oe_o)
        else $error("output driven while deselected");
    AST_RESET_PIN_IDLE: assert property (s_in_reset |-> !so_oe_o)
        else $error("output driven during reset pin");
    AST_QUIET_LOW: assert property (!so_oe_o |-> !so_o)
        else $error("data high while not driving");
    AST_SHIFT_ON_FALL: assert property (
        $changed(so_o) && so_oe_o && $past(so_oe_o) |-> s_after_fall)
        else $error("data changed away from a clock fall");
    AST_STABLE_SCK_HIGH: assert property (s_sck_held_high |-> $stable(so_o))
        else $error("data changed while clock high");
    AST_FIRST_BIT_ON_FALL: assert property (
        $rose(so_oe_o) |-> s_after_fall ##0 ($past(cs_n_i, 8) == 1'b0))
        else $error("drive began away from a clock fall");
    AST_OE_HOLDS: assert property (
        so_oe_o && !cs_n_i && flash_reset_n_i |=> so_oe_o)
        else $error("drive dropped while selected");
    AST_IDLE_AFTER_RESET: assert property ($rose(rst_n_i) |-> !so_oe_o [*3])
        else $error("output driven after reset");
endmodule : sfr_read_props

/* File: verif/sfr_host_model.sv */
// sfr_host_model: serial host driving chip select, clock and data in.
// assumes: half a serial period is ten cycles of ref_clk_i (80 ns).
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic ref_clk_i,
    input  wire logic so_i,
    input  wire logic so_oe_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    logic idle_lvl;
    // pins idle, clock standing still outside frames
    initial begin
        cs_n_o   = 1'b1;
        sck_o    = 1'b0;
        si_o     = 1'b0;
        idle_lvl = 1'b0;
    end
    // half a serial period, changes land at falling ref edges
    task automatic half();
        repeat (10) @(negedge ref_clk_i);
    endtask : half
    // open a frame in clock mode 0 or 3
    task automatic open(input logic mode3);
        idle_lvl = mode3;
        sck_o    = mode3;
        half();
        cs_n_o = 1'b0;
        half();
    endtask : open
    // one bit each way; undriven output reads as unknown
    task automatic xbit(input logic b, output logic r);
        sck_o = 1'b0;
        si_o  = b;
        half();
        r     = so_oe_i ? so_i : 1'bx;
        sck_o = 1'b1;
        half();
    endtask : xbit
    task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], r[i]);
        end
    endtask : xbyte
    // clock back to idle level, then deselect
    task automatic close();
        sck_o = idle_lvl;
        si_o  = ~si_o;
        half();
        cs_n_o = 1'b1;
        half();
    endtask : close
endmodule : sfr_host_model

/* File: verif/sfr_read_top_test.sv */
// sfr_read_top_test: read commands, wraps, refusals and reset pin.
// assumes: array loaded through the fill port; host model drives the pins.
`timescale 1ns/1ps
module sfr_read_top_test;
    import sfr_pkg::*;
    logic                    ref_clk;
    logic                    rst_n;
    logic                    flash_reset_n;
    logic                    binary_page;
    logic                    fill_en;
    logic [SFR_ARRAY_AW-1:0] fill_addr;
    logic [7:0]              fill_data;
    logic                    cs_n;
    logic                    sck;
    logic                    si;
    logic                    so;
    logic                    so_oe;
    int                      n_fail;
    int                      checked;

    sfr_read_top DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .flash_reset_n_i(flash_reset_n), .binary_page_i(binary_page),
        .so_o(so), .so_oe_o(so_oe), .fill_en_i(fill_en), .fill_addr_i(fill_addr),
        .fill_data_i(fill_data));
    sfr_host_model u_host (.ref_clk_i(ref_clk), .so_i(so), .so_oe_i(so_oe),
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    // 125 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // backdoor load of one byte at a linear index
    task automatic fill(input int lin, input logic [7:0] d);
        @(negedge ref_clk);
        fill_en   = 1'b1;
        fill_addr = lin[SFR_ARRAY_AW-1:0];
        fill_data = d;
        @(negedge ref_clk);
        fill_en = 1'b0;
    endtask : fill
    // opcode, three address bytes, filler bytes that must be ignored
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nfill,
                       input logic m3);
        logic [7:0] r;
        u_host.open(m3);
        u_host.xbyte(op, r);
        for (int i = 2; i >= 0; i--) begin
            u_host.xbyte(a[8*i +: 8], r);
        end
        repeat (nfill) u_host.xbyte(8'ha5, r);
        // header over, first data fall still ahead: output must float
        check({7'h00, so_oe}, 8'h00, "drive in header");
    endtask : cmd
    task automatic rd(input logic [7:0] exp, input string what);
        logic [7:0] r;
        u_host.xbyte(8'h00, r);
        check(r, exp, what);
    endtask : rd
    task automatic done();
        u_host.close();
        check({7'h00, so_oe}, 8'h00, "drive after deselect");
    endtask : done

    task automatic t_slow_cross();
        binary_page = 1'b0;
        fill(1582, 8'h5a);
        fill(1583, 8'ha5);
        fill(1584, 8'h3c);
        cmd(SFR_OP_SLOW_READ, 24'h000b06, 0, 1'b0);
        rd(8'h5a, "slow start byte");
        rd(8'ha5, "slow page end");
        rd(8'h3c, "slow next page");
        done();
        $display("test slow read page crossing ended");
    endtask : t_slow_cross
    task automatic t_legacy_wrap();
        fill(270335, 8'h81);
        fill(0, 8'h7e);
        cmd(SFR_OP_LEGACY_READ, 24'hffff07, 4, 1'b0);
        rd(8'h81, "last array byte");
        rd(8'h7e, "array wrap");
        done();
        $display("test legacy read array wrap ended");
    endtask : t_legacy_wrap
    task automatic t_fast_binary();
        binary_page = 1'b1;
        fill(783, 8'hc3);
        fill(792, 8'h18);
        cmd(SFR_OP_FAST_READ, 24'hfc02ff, 1, 1'b0);
        rd(8'hc3, "binary page end");
        rd(8'h18, "binary next page");
        done();
        binary_page = 1'b0;
        $display("test fast read binary pages ended");
    endtask : t_fast_binary
    task automatic t_page_mode3();
        fill(2111, 8'he1);
        fill(1848, 8'h1e);
        cmd(SFR_OP_PAGE_READ, 24'h000f07, 4, 1'b1);
        rd(8'he1, "page read end");
        rd(8'h1e, "page read same page");
        done();
        $display("test page read mode 3 ended");
    endtask : t_page_mode3
    task automatic t_refused();
        cmd(8'h55, 24'h000000, 0, 1'b0);
        rd(8'hxx, "unknown opcode drives");
        done();
        $display("test unknown opcode ended");
    endtask : t_refused
    task automatic t_reset_pin();
        cmd(SFR_OP_SLOW_READ, 24'h000b06, 0, 1'b0);
        rd(8'h5a, "read before reset pin");
        flash_reset_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        check({7'h00, so_oe}, 8'h00, "drive in reset pin");
        flash_reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        done();
        cmd(SFR_OP_SLOW_READ, 24'h000b06, 0, 1'b0);
        rd(8'h5a, "read after reset pin");
        done();
        $display("test reset pin abort ended");
    endtask : t_reset_pin

    task automatic stop_test();
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // watchdog well beyond the expected run of about 8200 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        stop_test();
    end
    // main sequence
    initial begin
        n_fail        = 0;
        checked       = 0;
        rst_n         = 1'b0;
        flash_reset_n = 1'b1;
        binary_page   = 1'b0;
        fill_en       = 1'b0;
        fill_addr     = '0;
        fill_data     = 8'h00;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_slow_cross();
        t_legacy_wrap();
        t_fast_binary();
        t_page_mode3();
        t_refused();
        t_reset_pin();
        stop_test();
    end
endmodule : sfr_read_top_test

bind sfr_read_top sfr_read_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .flash_reset_n_i(flash_reset_n_i), .so_o(so_o),
    .so_oe_o(so_oe_o));
